// ---- rtl/cis_sequencer.sv ----
// Interrupt sequencer: arbitration, flags, entry and return, AXI4-Lite registers
// Function
// [RULE_01] Reset and per-source vectors at lowest addresses
// [RULE_02] Lower vector wins; reset, then external_request_zero
// [RULE_03] Take only with source and global enable
// [RULE_04] Accepting an interrupt clears global enable
// [RULE_05] Software may set global enable, allowing nesting
// [RULE_06] Return from handler sets global enable
// [RULE_07] Event sources: vector taken, flag cleared by hardware
// [RULE_08] Writing one clears a flag, zero keeps
// [RULE_09] Disabled event still sets and keeps flag
// [RULE_10] Pending flags served in priority once enabled
// [RULE_11] Condition sources request only while present
// [RULE_12] One main instruction after return before next
// [RULE_13] Status flags not saved or restored
// [RULE_14] Clear-enable instruction blocks even simultaneous requests
// [RULE_15] Instruction after set-enable runs before servicing
// [RULE_16] Entry four cycles, program counter pushed
// [RULE_17] Vector jump takes three cycles
// [RULE_18] Multi-cycle instruction finishes before entry
// [RULE_19] Wake from sleep adds four cycles
// [RULE_20] Return four cycles, pop two bytes, enable
// [RULE_21] Runs on undivided core clock
// [RULE_22] Entry decrements stack pointer by two
// [RULE_23] Pushed address is the next instruction
module cis_sequencer #(
   parameter logic [cis_pkg::NSRC-1:0] LEVEL_MASK = 8'h00  // Set bits: condition-type sources
) (
   // Clock and reset
   input  wire logic                      aclk,
   input  wire logic                      aresetn,
   // Interrupt sources
   input  wire logic [cis_pkg::NSRC-1:0]  src_event,
   input  wire logic [cis_pkg::NSRC-1:0]  src_cond,
   // Core pipeline
   input  wire cis_pkg::cis_core_in_t     core_in,
   output cis_pkg::cis_core_out_t         core_out,
   // Stack memory
   output cis_pkg::cis_stack_t            stack,
   input  wire logic [7:0]                stack_rdata,
   // AXI4-Lite write address
   input  wire logic                      s_axi_awvalid,
   output logic                           s_axi_awready,
   input  wire logic [5:0]                s_axi_awaddr,
   // AXI4-Lite write data
   input  wire logic                      s_axi_wvalid,
   output logic                           s_axi_wready,
   input  wire logic [31:0]               s_axi_wdata,
   input  wire logic [3:0]                s_axi_wstrb,
   // AXI4-Lite write response
   output logic                           s_axi_bvalid,
   input  wire logic                      s_axi_bready,
   output logic [1:0]                     s_axi_bresp,
   // AXI4-Lite read address
   input  wire logic                      s_axi_arvalid,
   output logic                           s_axi_arready,
   input  wire logic [5:0]                s_axi_araddr,
   // AXI4-Lite read data
   output logic                           s_axi_rvalid,
   input  wire logic                      s_axi_rready,
   output logic [31:0]                    s_axi_rdata,
   output logic [1:0]                     s_axi_rresp
);

   localparam int NSRC = cis_pkg::NSRC;
   localparam int IDXW = cis_pkg::IDXW;
   localparam int PCW  = cis_pkg::PCW;
   localparam int SPW  = cis_pkg::SPW;

   cis_pkg::cis_regs_t r_r;             // Registered state
   cis_pkg::cis_regs_t r_nxt;           // Next state

   logic [NSRC-1:0] req;                // Raw request per source
   logic [NSRC-1:0] armed;              // Requests passing both enables
   logic            any_armed;          // Some request may be taken
   logic [IDXW-1:0] win;                // Winning source index
   logic            take;               // Entry starts this cycle
   logic            do_wr;              // Register write happens this cycle
   logic [31:0]     rd_mux;             // Read data for the addressed register
   logic            rd_hit;             // Read address is mapped
   logic            wr_hit;             // Write address is mapped
   logic [NSRC-1:0] w1c;                // Flags cleared by software

   // Vector address of a source; reset owns the first slot
   function automatic logic [PCW-1:0] vec_of(input logic [IDXW-1:0] idx);
      logic [PCW-1:0] slot;
      slot = PCW'(idx) + 12'h001;
      vec_of = cis_pkg::RESET_VEC + PCW'(slot * cis_pkg::VEC_STRIDE);  // RULE_01
   endfunction

   // Request per source: latched flag or live condition
   genvar g;
   generate
      for (g = 0; g < NSRC; g++) begin : g_req
         assign req[g] = LEVEL_MASK[g] ? src_cond[g] : r_r.flags[g];  // RULE_11 RULE_07
      end
   endgenerate

   // Both enables gate every source
   assign armed     = req & r_r.en & {NSRC{r_r.gie}};  // RULE_03 RULE_10
   assign any_armed = |armed;

   // Fixed priority: lowest index, lowest vector
   always_comb begin
      win = '0;
      for (int i = NSRC - 1; i >= 0; i--) begin
         if (armed[i]) begin
            win = IDXW'(i);  // RULE_02
         end
      end
   end

   // Entry is taken only at an instruction boundary or from sleep
   assign take = (r_r.state == cis_pkg::S_RUN) && any_armed && !r_r.hold
                 && !core_in.op_cli                                      // RULE_14
                 && (core_in.instr_done || core_in.sleeping);            // RULE_18

   // Bus write fires once address and data are both held
   assign do_wr = r_r.aw_got && r_r.w_got && !r_r.bvalid;

   // Write address decode
   always_comb begin
      unique case (r_r.awaddr)
         cis_pkg::OFS_CTRL, cis_pkg::OFS_ENABLE, cis_pkg::OFS_FLAGS,
         cis_pkg::OFS_SP: wr_hit = 1'b1;
         default:         wr_hit = 1'b0;
      endcase
   end

   // Software flag clears, ones clear and zeros keep
   assign w1c = (do_wr && r_r.awaddr == cis_pkg::OFS_FLAGS && r_r.wstrb[0])
                ? r_r.wdata[NSRC-1:0] : '0;  // RULE_08

   // Read data decode
   always_comb begin
      rd_mux = '0;
      rd_hit = 1'b1;
      unique case (s_axi_araddr)
         cis_pkg::OFS_CTRL:   rd_mux[cis_pkg::GIE_BIT] = r_r.gie;
         cis_pkg::OFS_ENABLE: rd_mux[NSRC-1:0] = r_r.en;
         cis_pkg::OFS_FLAGS:  rd_mux[NSRC-1:0] = r_r.flags;
         cis_pkg::OFS_PEND:   rd_mux[NSRC-1:0] = req;
         cis_pkg::OFS_SP:     rd_mux[SPW-1:0] = r_r.sp;
         cis_pkg::OFS_STATE:  rd_mux = {23'h000000, r_r.hold, IDXW'(r_r.cur), 1'b0,
                                        r_r.state};
         default:             rd_hit = 1'b0;
      endcase
   end

   // Next-state logic for sequencer, registers and bus
   always_comb begin
      r_nxt = r_r;

      // Event flags: set wins over any clear in the same cycle
      r_nxt.flags = (r_r.flags & ~w1c) | (src_event & ~LEVEL_MASK);  // RULE_09 RULE_08

      // Register writes
      if (do_wr) begin
         unique case (r_r.awaddr)
            cis_pkg::OFS_CTRL: begin
               if (r_r.wstrb[0]) begin
                  r_nxt.gie = r_r.wdata[cis_pkg::GIE_BIT];  // RULE_05
               end
            end
            cis_pkg::OFS_ENABLE: begin
               if (r_r.wstrb[0]) begin
                  r_nxt.en = r_r.wdata[NSRC-1:0];
               end
            end
            // Stack pointer uses lanes 0 and 1
            cis_pkg::OFS_SP: begin
               for (int b = 0; b < 2; b++) begin
                  if (r_r.wstrb[b]) begin
                     r_nxt.sp[8*b +: 8] = r_r.wdata[8*b +: 8];
                  end
               end
            end
            default: ;
         endcase
      end

      // Instructions from the core touching the enable bit
      if (core_in.instr_done && r_r.state == cis_pkg::S_RUN) begin
         if (core_in.op_sei) begin
            r_nxt.gie  = 1'b1;
            r_nxt.hold = 1'b1;  // RULE_15
         end else begin
            r_nxt.hold = 1'b0;  // RULE_12
         end
         if (core_in.op_cli) begin
            r_nxt.gie = 1'b0;  // RULE_14
         end
      end

      // Sequencer; status_flags_register other bits are never touched
      unique case (r_r.state)
         cis_pkg::S_RUN: begin
            if (take) begin
               r_nxt.gie     = 1'b0;                 // RULE_04
               r_nxt.cur     = win;
               r_nxt.pc_save = core_in.next_pc;      // RULE_23 RULE_13
               if (!LEVEL_MASK[win]) begin
                  r_nxt.flags[win] = src_event[win];  // RULE_07
               end
               if (core_in.sleeping) begin
                  r_nxt.state = cis_pkg::S_WAKE;
                  r_nxt.cnt   = cis_pkg::WAKE_EXTRA - 3'h1;  // RULE_19
               end else begin
                  r_nxt.state = cis_pkg::S_PUSH_LO;
               end
            end else if (core_in.op_return_from_handler_instr && core_in.instr_done) begin
               r_nxt.state = cis_pkg::S_POP_HI;
            end
         end
         cis_pkg::S_WAKE: begin
            r_nxt.cnt = r_r.cnt - 3'h1;
            if (r_r.cnt == 3'h0) begin
               r_nxt.state = cis_pkg::S_PUSH_LO;  // RULE_19
            end
         end
         // Four entry cycles: two pushes, settle, vector load
         cis_pkg::S_PUSH_LO: r_nxt.state = cis_pkg::S_PUSH_HI;  // RULE_16
         cis_pkg::S_PUSH_HI: r_nxt.state = cis_pkg::S_ENT2;
         cis_pkg::S_ENT2:    r_nxt.state = cis_pkg::S_ENT3;
         cis_pkg::S_ENT3: begin
            r_nxt.sp    = r_r.sp - 16'h0002;                   // RULE_22
            r_nxt.state = cis_pkg::S_VJMP;
            r_nxt.cnt   = cis_pkg::JUMP_CYCLES - 3'h1;
         end
         cis_pkg::S_VJMP: begin
            r_nxt.cnt = r_r.cnt - 3'h1;
            if (r_r.cnt == 3'h0) begin
               r_nxt.state = cis_pkg::S_RUN;  // RULE_17
            end
         end
         // Four return cycles: pop high, pop low, settle, reload
         cis_pkg::S_POP_HI: r_nxt.state = cis_pkg::S_POP_LO;  // RULE_20
         cis_pkg::S_POP_LO: begin
            r_nxt.pc_save[PCW-1:8] = stack_rdata[PCW-9:0];
            r_nxt.state            = cis_pkg::S_RET2;
         end
         cis_pkg::S_RET2: begin
            r_nxt.pc_save[7:0] = stack_rdata;
            r_nxt.state        = cis_pkg::S_RET3;
         end
         cis_pkg::S_RET3: begin
            r_nxt.sp    = r_r.sp + 16'h0002;  // RULE_20
            r_nxt.gie   = 1'b1;               // RULE_06
            r_nxt.hold  = 1'b1;               // RULE_12
            r_nxt.state = cis_pkg::S_RUN;
         end
      endcase

      // Write channel: address and data taken in either order
      if (s_axi_awvalid && !r_r.aw_got) begin
         r_nxt.aw_got = 1'b1;
         r_nxt.awaddr = s_axi_awaddr;
      end
      if (s_axi_wvalid && !r_r.w_got) begin
         r_nxt.w_got = 1'b1;
         r_nxt.wdata = s_axi_wdata;
         r_nxt.wstrb = s_axi_wstrb;
      end
      if (do_wr) begin
         r_nxt.bvalid = 1'b1;
         r_nxt.bresp  = wr_hit ? cis_pkg::RESP_OKAY : cis_pkg::RESP_SLVERR;
      end
      if (r_r.bvalid && s_axi_bready) begin
         r_nxt.bvalid = 1'b0;
         r_nxt.aw_got = 1'b0;
         r_nxt.w_got  = 1'b0;
      end

      // Read channel: answer one cycle after address
      if (s_axi_arvalid && !r_r.rvalid) begin
         r_nxt.rvalid = 1'b1;
         r_nxt.rdata  = rd_mux;
         r_nxt.rresp  = rd_hit ? cis_pkg::RESP_OKAY : cis_pkg::RESP_SLVERR;
      end else if (r_r.rvalid && s_axi_rready) begin
         r_nxt.rvalid = 1'b0;
      end
   end

   // State register on the undivided core clock
   always_ff @(posedge aclk) begin  // RULE_21
      if (!aresetn) begin
         r_r       <= '0;
         r_r.state <= cis_pkg::S_RUN;
         r_r.sp    <= cis_pkg::SP_RESET;
         r_r.en    <= cis_pkg::EN_RESET;
      end else begin
         r_r <= r_nxt;
      end
   end

   // Core side outputs
   always_comb begin
      core_out          = '0;
      core_out.stall    = (r_r.state != cis_pkg::S_RUN) && (r_r.state != cis_pkg::S_VJMP);
      core_out.gie      = r_r.gie;
      core_out.wake     = (r_r.state == cis_pkg::S_WAKE);
      core_out.in_jump  = (r_r.state == cis_pkg::S_VJMP);
      core_out.pc_load  = (r_r.state == cis_pkg::S_ENT3) || (r_r.state == cis_pkg::S_RET3);
      core_out.pc_value = (r_r.state == cis_pkg::S_ENT3) ? vec_of(r_r.cur) : r_r.pc_save;
   end

   // Stack port: low byte at SP, high byte below it
   always_comb begin
      stack = '0;
      unique case (r_r.state)
         cis_pkg::S_PUSH_LO: begin
            stack.wr    = 1'b1;
            stack.addr  = r_r.sp;
            stack.wdata = r_r.pc_save[7:0];  // RULE_16
         end
         cis_pkg::S_PUSH_HI: begin
            stack.wr    = 1'b1;
            stack.addr  = r_r.sp - 16'h0001;
            stack.wdata = 8'(r_r.pc_save[PCW-1:8]);
         end
         cis_pkg::S_POP_HI: begin
            stack.rd   = 1'b1;
            stack.addr = r_r.sp + 16'h0001;
         end
         cis_pkg::S_POP_LO: begin
            stack.rd   = 1'b1;
            stack.addr = r_r.sp + 16'h0002;
         end
         default: ;
      endcase
   end

   // Bus handshakes
   assign s_axi_awready = !r_r.aw_got;
   assign s_axi_wready  = !r_r.w_got;
   assign s_axi_bvalid  = r_r.bvalid;
   assign s_axi_bresp   = r_r.bresp;
   assign s_axi_arready = !r_r.rvalid;
   assign s_axi_rvalid  = r_r.rvalid;
   assign s_axi_rdata   = r_r.rdata;
   assign s_axi_rresp   = r_r.rresp;

endmodule

// ---- rtl/cis_pkg.sv ----
// Package: constants, register map and carrier types of the interrupt sequencer
package cis_pkg;

   // Sizes
   localparam int NSRC   = 8;                 // Vectored sources, index 0 is external_request_zero
   localparam int IDXW   = $clog2(NSRC);      // Source index width
   localparam int PCW    = 12;                // Program counter width (words)
   localparam int SPW    = 16;                // Stack pointer width (bytes)

   // Vector table
   localparam logic [PCW-1:0] RESET_VEC  = 12'h000;  // Reset vector, lowest address
   localparam logic [PCW-1:0] VEC_STRIDE = 12'h001;  // Words between vectors

   // Timing, in core_clock cycles (core_clock is aclk, undivided)
   localparam logic [2:0] ENTRY_CYCLES = 3'h4;  // Push and vector load
   localparam logic [2:0] WAKE_EXTRA   = 3'h4;  // Added when entry wakes from sleep
   localparam logic [2:0] JUMP_CYCLES  = 3'h3;  // Jump at the vector
   localparam logic [2:0] RET_CYCLES   = 3'h4;  // Pop and enable on return

   // Register map, byte addresses
   localparam logic [5:0] OFS_CTRL   = 6'h00;  // Global enable in bit 7
   localparam logic [5:0] OFS_ENABLE = 6'h04;  // Per-source enables
   localparam logic [5:0] OFS_FLAGS  = 6'h08;  // Latched flags, write one to clear
   localparam logic [5:0] OFS_PEND   = 6'h0C;  // Requests currently seen, read only
   localparam logic [5:0] OFS_SP     = 6'h10;  // Stack pointer
   localparam logic [5:0] OFS_STATE  = 6'h14;  // Sequencer state, read only

   // Field positions and reset values
   localparam int GIE_BIT = 7;                          // Global enable in CTRL
   localparam logic [SPW-1:0] SP_RESET  = 16'h025F;     // Stack top after reset
   localparam logic [NSRC-1:0] EN_RESET = 8'h00;        // All sources disabled
   localparam logic [1:0] RESP_OKAY   = 2'h0;
   localparam logic [1:0] RESP_SLVERR = 2'h2;

   // Sequencer states
   typedef enum logic [3:0] {
      S_RUN, S_WAKE, S_PUSH_LO, S_PUSH_HI, S_ENT2, S_ENT3, S_VJMP,
      S_POP_HI, S_POP_LO, S_RET2, S_RET3
   } cis_state_t;

   // From the core pipeline
   typedef struct packed {
      logic           instr_done;  // Current instruction completes this cycle
      logic [PCW-1:0] next_pc;     // Address of the instruction that would run next
      logic           op_sei;      // Completing instruction sets global enable
      logic           op_cli;      // Completing instruction clears global enable
      logic           op_return_from_handler_instr;     // return_from_handler_instr decoded, start return
      logic           sleeping;    // Core is in a sleep mode, start-up already done
   } cis_core_in_t;

   // To the core pipeline
   typedef struct packed {
      logic           stall;       // Hold fetch and execute
      logic           pc_load;     // Load pc_value into the program counter
      logic [PCW-1:0] pc_value;    // Vector or return address
      logic           gie;         // Global enable bit of status_flags_register
      logic           wake;        // Leave sleep
      logic           in_jump;     // Vector jump cycles under way
   } cis_core_out_t;

   // Stack port to data memory
   typedef struct packed {
      logic           wr;          // Write one byte
      logic           rd;          // Read one byte, data returns next cycle
      logic [SPW-1:0] addr;        // Byte address
      logic [7:0]     wdata;       // Byte to push
   } cis_stack_t;

   // Whole sequencer state
   typedef struct packed {
      cis_state_t      state;
      logic [2:0]      cnt;
      logic            gie;
      logic            hold;
      logic [NSRC-1:0] flags;
      logic [NSRC-1:0] en;
      logic [SPW-1:0]  sp;
      logic [PCW-1:0]  pc_save;
      logic [IDXW-1:0] cur;
      logic            aw_got;
      logic            w_got;
      logic [5:0]      awaddr;
      logic [31:0]     wdata;
      logic [3:0]      wstrb;
      logic            bvalid;
      logic [1:0]      bresp;
      logic            rvalid;
      logic [31:0]     rdata;
      logic [1:0]      rresp;
   } cis_regs_t;

endpackage

// ---- sim/cis_sequencer_checker.sv ----
// Checker: entry, return and gating timing of the interrupt sequencer
module cis_sequencer_checker (
   // Clock and reset
   input wire logic                   aclk,
   input wire logic                   aresetn,
   // Core side
   input wire cis_pkg::cis_core_in_t  core_in,
   input wire cis_pkg::cis_core_out_t core_out,
   input wire cis_pkg::cis_stack_t    stack
);
   timeunit 1ns;
   timeprecision 1ps;
   default clocking cb @(posedge aclk); endclocking
   default disable iff (!aresetn);

   // Two pushes, a gap, the vector load
   chk_entry_push: assert property ($rose(stack.wr) |=> stack.wr ##1 !stack.wr
      ##1 core_out.pc_load) else $error("entry push wrong");
   // Second push one byte lower
   chk_push_down: assert property (stack.wr && $past(stack.wr)
      |-> stack.addr == $past(stack.addr) - 16'h0001) else $error("push address wrong");
   // Low byte of the next address first
   chk_push_pc: assert property ($rose(stack.wr) && $past(core_in.instr_done)
      |-> stack.wdata == $past(core_in.next_pc[7:0])) else $error("pushed address wrong");
   // Enable drops on entry
   chk_entry_gie: assert property ($rose(stack.wr) |=> !core_out.gie)
      else $error("enable kept on entry");
   // Load, then three jump cycles
   chk_vector_jump: assert property ($rose(stack.wr) |-> ##3 core_out.pc_load
      ##1 core_out.in_jump [*3] ##1 !core_out.in_jump) else $error("jump length wrong");
   // Two pops upward, load, enable set
   chk_ret_pop: assert property ($rose(stack.rd) |=> stack.rd
      && stack.addr == $past(stack.addr) + 16'h0001 ##2 core_out.pc_load ##1 core_out.gie)
      else $error("return sequence wrong");
   // Clear-enable blocks a simultaneous request
   chk_cli_block: assert property (core_in.instr_done && core_in.op_cli
      && !core_out.stall |=> !stack.wr && !core_out.gie && !core_out.wake)
      else $error("entry after clear-enable");
   // Next instruction runs first
   chk_sei_next: assert property (core_in.instr_done && core_in.op_sei
      && !core_out.stall |=> !stack.wr && !core_out.wake) else $error("entry after set-enable");
   // Entry at an instruction end or after waking
   chk_multi_done: assert property ($rose(stack.wr)
      |-> $past(core_in.instr_done) || $past(core_out.wake)) else $error("entry mid-instruction");
   // Four wake cycles, then the push
   chk_wake_four: assert property ($rose(core_out.wake)
      |-> core_out.wake [*4] ##1 (stack.wr && !core_out.wake)) else $error("wake length wrong");
endmodule

bind cis_sequencer cis_sequencer_checker u_cis_sequencer_checker (
   .aclk(aclk), .aresetn(aresetn), .core_in(core_in), .core_out(core_out), .stack(stack));

// ---- sim/cis_core_model.sv ----
// Partner model: byte stack memory answering the sequencer's pushes and pops
module cis_core_model (
   // Clock
   input wire logic                aclk,
   // Stack port
   input wire cis_pkg::cis_stack_t stack,
   output logic [7:0]              stack_rdata
);
   timeunit 1ns;
   timeprecision 1ps;
   logic [7:0] mem [logic [15:0]];  // Written bytes only

   initial stack_rdata = 8'h5A;
   // Store pushes; read data valid only the cycle after a read, else churns
   always @(posedge aclk) begin
      if (stack.wr) begin
         mem[stack.addr] = stack.wdata;
      end
      if (stack.rd) begin
         stack_rdata <= mem.exists(stack.addr) ? mem[stack.addr] : 8'h00;
      end else begin
         stack_rdata <= ~stack_rdata;
      end
   end
endmodule

// ---- sim/cpu_interrupt_sequencer_tb_top.sv ----
// Testbench: directed scenarios for the interrupt sequencer
module cpu_interrupt_sequencer_tb_top;
   timeunit 1ns;
   timeprecision 1ps;
   localparam logic [31:0] ENT = 32'(cis_pkg::ENTRY_CYCLES);  // Entry length
   localparam logic [31:0] VS  = 32'(cis_pkg::VEC_STRIDE);    // Vector spacing
   // Clock, reset, sources, core
   logic                   aclk = 1'b0;
   logic                   aresetn = 1'b0;
   logic [7:0]             src_event = 8'h00;
   logic [7:0]             src_cond = 8'h00;
   cis_pkg::cis_core_in_t  core_in = '0;
   cis_pkg::cis_core_out_t core_out;
   cis_pkg::cis_stack_t    stack;
   logic [7:0]             stack_rdata;
   // Register bus
   logic        awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
   logic        awready, wready, bvalid, arready, rvalid;
   logic [5:0]  awaddr = 6'h00, araddr = 6'h00;
   logic [31:0] wdata = 32'h0, rdata;
   logic [1:0]  bresp, rresp, r;
   logic [31:0] d, pc;
   int          err_count = 0, checks_done = 0, cycles = 0, n;

   always #10 aclk = ~aclk;

   cis_sequencer #(.LEVEL_MASK(8'h80)) u_cis_sequencer (
      .aclk(aclk), .aresetn(aresetn), .src_event(src_event), .src_cond(src_cond),
      .core_in(core_in), .core_out(core_out), .stack(stack), .stack_rdata(stack_rdata),
      .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_awaddr(awaddr),
      .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_wdata(wdata),
      .s_axi_wstrb(4'hF), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
      .s_axi_bresp(bresp), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
      .s_axi_araddr(araddr), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
      .s_axi_rdata(rdata), .s_axi_rresp(rresp));
   cis_core_model u_cis_core_model (.aclk(aclk), .stack(stack), .stack_rdata(stack_rdata));

   // Compare and count
   task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
      checks_done++;
      if (got !== exp) begin
         err_count++;
         $display("Error %0t %s got %h expected %h", $time, what, got, exp);
      end
   endtask
   // Register write
   task automatic axw(input logic [5:0] a, input logic [31:0] v);
      @(posedge aclk);
      awvalid <= 1'b1; awaddr <= a; wvalid <= 1'b1; wdata <= v; bready <= 1'b1;
      do begin
         @(posedge aclk);
         if (awvalid && awready) awvalid <= 1'b0;
         if (wvalid && wready) wvalid <= 1'b0;
      end while (!(bvalid && bready));
      r = bresp;
      bready <= 1'b0;
   endtask
   // Register read
   task automatic axr(input logic [5:0] a);
      @(posedge aclk);
      arvalid <= 1'b1; araddr <= a; rready <= 1'b1;
      do begin
         @(posedge aclk);
         if (arvalid && arready) arvalid <= 1'b0;
      end while (!(rvalid && rready));
      d = rdata; r = rresp;
      rready <= 1'b0;
   endtask
   // One completed instruction
   task automatic step(input logic sei, input logic cli, input logic return_from_handler_instr, input logic [11:0] npc);
      @(posedge aclk);
      core_in.instr_done <= 1'b1; core_in.op_sei <= sei; core_in.op_cli <= cli;
      core_in.op_return_from_handler_instr <= return_from_handler_instr; core_in.next_pc <= npc;
      @(posedge aclk);
      core_in.instr_done <= 1'b0; core_in.op_sei <= 1'b0; core_in.op_cli <= 1'b0;
      core_in.op_return_from_handler_instr <= 1'b0;
   endtask
   // Cycles to a pc load, 0 if none
   task automatic wait_load(input int lim);
      n = 0; pc = 32'h0;
      for (int i = 1; i <= lim && n == 0; i++) begin
         @(posedge aclk);
         if (core_out.pc_load === 1'b1) begin
            n = i; pc = {20'h0, core_out.pc_value};
         end
      end
      repeat (4) @(posedge aclk);
   endtask
   task automatic pulse(input logic [7:0] m);
      @(posedge aclk); src_event <= m;
      @(posedge aclk); src_event <= 8'h00;
   endtask
   // Plain instruction; return from handler
   task automatic nop(input logic [11:0] npc);
      step(1'b0, 1'b0, 1'b0, npc);
   endtask
   task automatic rti;
      step(1'b0, 1'b0, 1'b1, 12'h000);
      wait_load(12);
   endtask

   // Reset values and an unmapped address
   task automatic t_reset_regs;
      axr(cis_pkg::OFS_CTRL);   chk(d, 32'h0, "ctrl reset");
      axr(cis_pkg::OFS_ENABLE); chk(d, 32'h0, "enable reset");
      axr(cis_pkg::OFS_SP);     chk(d, 32'h025F, "sp reset");
      axr(6'h18);               chk({30'h0, r}, 32'h2, "unmapped read resp");
      axw(6'h18, 32'hFF);       chk({30'h0, r}, 32'h2, "unmapped write resp");
   endtask
   // Disabled event keeps its flag; write one clears
   task automatic t_flags;
      pulse(8'h08);
      axr(cis_pkg::OFS_FLAGS); chk(d, 32'h08, "flag set while disabled");
      axw(cis_pkg::OFS_FLAGS, 32'h00);
      axr(cis_pkg::OFS_FLAGS); chk(d, 32'h08, "zero write kept flag");
      axw(cis_pkg::OFS_FLAGS, 32'h08);
      axr(cis_pkg::OFS_FLAGS); chk(d, 32'h00, "one write cleared flag");
      pulse(8'h06);
   endtask
   // Pending pair after set-enable: priority, push, vector
   task automatic t_entry;
      axw(cis_pkg::OFS_ENABLE, 32'h06);
      step(1'b1, 1'b0, 1'b0, 12'h100);
      nop(12'h101);
      wait_load(6); chk(n, 32'h0, "entry after sei");
      nop(12'h123);
      wait_load(12); chk(n, ENT, "entry cycles");
      chk(pc, VS * 2, "vector 1");
      chk({24'h0, u_cis_core_model.mem[16'h025F]}, 32'h23, "pushed low byte");
      chk({24'h0, u_cis_core_model.mem[16'h025E]}, 32'h01, "pushed high byte");
      axr(cis_pkg::OFS_SP);    chk(d, 32'h025D, "sp after entry");
      axr(cis_pkg::OFS_FLAGS); chk(d, 32'h04, "taken flag cleared");
      axr(cis_pkg::OFS_CTRL);  chk(d, 32'h00, "enable off in handler");
   endtask
   // Return, one instruction, then the next pending source
   task automatic t_return;
      rti(); chk(n, 32'(cis_pkg::RET_CYCLES), "return cycles");
      chk(pc, 32'h123, "return address");
      axr(cis_pkg::OFS_CTRL); chk(d, 32'h80, "enable set by return");
      axr(cis_pkg::OFS_SP);   chk(d, 32'h025F, "sp after return");
      nop(12'h124);
      wait_load(6); chk(n, 32'h0, "one instruction after return");
      nop(12'h125);
      wait_load(12); chk(pc, VS * 3, "next pending");
      rti();
      nop(12'h130);
   endtask
   // Clear-enable with a request already waiting
   task automatic t_cli;
      pulse(8'h02);
      step(1'b0, 1'b1, 1'b0, 12'h131);
      wait_load(6); chk(n, 32'h0, "no entry after clear-enable");
      axr(cis_pkg::OFS_CTRL); chk(d, 32'h00, "enable cleared");
      axw(cis_pkg::OFS_FLAGS, 32'h02);
   endtask
   // Condition source: gone before enabling, then held
   task automatic t_cond;
      axw(cis_pkg::OFS_ENABLE, 32'h80);
      @(posedge aclk); src_cond <= 8'h80;
      repeat (3) @(posedge aclk);
      src_cond <= 8'h00;
      step(1'b1, 1'b0, 1'b0, 12'h132);
      nop(12'h133);
      nop(12'h134);
      wait_load(6); chk(n, 32'h0, "vanished condition ignored");
      @(posedge aclk); src_cond <= 8'h80;
      nop(12'h140);
      wait_load(12); chk(pc, VS * 8, "condition vector");
      src_cond <= 8'h00;
      rti();
      nop(12'h141);
   endtask
   // Request waiting while the core sleeps
   task automatic t_sleep;
      axw(cis_pkg::OFS_ENABLE, 32'h81);
      pulse(8'h01);
      @(posedge aclk); core_in.sleeping <= 1'b1;
      wait_load(20); chk(n, 32'h1 + 32'(cis_pkg::WAKE_EXTRA) + ENT, "wake entry");
      chk(pc, VS, "source 0 vector");
      core_in.sleeping <= 1'b0;
   endtask

   task automatic conclude;
      $display("Comparisons %0d mismatches %0d", checks_done, err_count);
      if (err_count == 0 && checks_done > 0) $display("STATUS OK");
      else $display("STATUS NOT OK");
      $finish;
   endtask

   // Hang guard
   always @(posedge aclk) begin
      cycles++;
      if (cycles == 20000) begin
         err_count++;
         conclude();
      end
   end

   initial begin
      repeat (12) @(posedge aclk);
      aresetn <= 1'b1;
      t_reset_regs();
      t_flags();
      t_entry();
      t_return();
      t_cli();
      t_cond();
      t_sleep();
      conclude();
   end
endmodule
